// ---- logic/ccp_compare_pwm.sv ----
// Purpose: Compare and standard PWM unit with APB register access
// Assumes: Timebase counter lives outside; CORE_CLK is the system clock
// Notes:   Overview of operation below
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ccp_compare_pwm (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  PADDR,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [15:0] TIMEBASE_COUNT,
    input  wire logic        TIMEBASE_TICK,
    input  wire logic        ADC_ENABLE,
    input  wire logic        SLEEP,
    output logic             CCP_OUT,
    output logic             CCP_OE,
    output logic             CONV_TRIG,
    output logic             CONV_START,
    output logic             TIMEBASE_CLEAR
);
    typedef enum logic [0:0] {ARM_IDLE, ARM_WAIT} arm_t;

    typedef struct packed {
        logic [5:0]  ctrl;
        logic [7:0]  duty_up;
        logic [7:0]  duty_buf;
        logic [1:0]  duty_lat;
        logic [7:0]  period;
        logic [2:0]  tctrl;
        logic [7:0]  count;
        logic        match_flag;
        logic        period_flag;
        logic        cmp_latch;
        logic        pin;
        logic        oe;
        logic        match_prev;
        logic        trig;
        logic        conv;
        logic        tb_clear;
        logic        out;
        arm_t        arm;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } state_t;

    state_t      s;
    state_t      next_s;
    logic        inc;
    logic [1:0]  low_bits;
    logic [3:0]  mode;
    logic        is_pwm;
    logic        is_cmp;
    logic        match;
    logic        hit;
    logic        rollover;
    logic        mapped;
    logic        wr;
    logic [9:0]  base;
    logic [9:0]  duty_new;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // Resolution in bits: 2 plus floor log2 of period plus one
    function automatic logic [3:0] resolution(input logic [7:0] pr);
        logic [8:0] v;
        logic [3:0] r;
        v = {1'b0, pr} + 9'h001;
        r = 4'h2;
        for (int i = 1; i < 9; i++) begin
            if (v[i]) begin
                r = 4'(i + 2);
            end
        end
        return r;
    endfunction

    // Pin driven only in output compare modes and PWM
    function automatic logic drives_pin(input logic [3:0] m);
        return (m == ccp_pkg::MODE_TOGGLE) || (m == ccp_pkg::MODE_SET) ||
               (m == ccp_pkg::MODE_CLR) || (m[3:2] == ccp_pkg::MODE_PWM_TOP);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Period timer prescaler, frozen in sleep
    ccp_tick_gen i_ccp_tick_gen (
        .clk      (CORE_CLK),
        .rst      (RST),
        .enable   (s.tctrl[ccp_pkg::TC_RUN] && !SLEEP),
        .prescale (s.tctrl[1:0]),
        .inc      (inc),
        .low_bits (low_bits)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode of mode, match and timebase
    assign mode     = s.ctrl[ccp_pkg::MODE_LSB +: 4];
    assign is_pwm   = (mode[3:2] == ccp_pkg::MODE_PWM_TOP);
    assign is_cmp   = drives_pin(mode) && !is_pwm || (mode == ccp_pkg::MODE_SWI) ||
                      (mode == ccp_pkg::MODE_TRIG);
    assign match    = (TIMEBASE_COUNT == {s.duty_buf, s.duty_up});
    assign hit      = is_cmp && match && !s.match_prev && !SLEEP;
    assign base     = {s.count, low_bits};
    assign rollover = inc && (s.count == s.period);
    assign duty_new = {s.duty_up, s.ctrl[ccp_pkg::DUTY_LO_LSB +: 2]};
    assign wr       = PSEL && PENABLE && s.pready && PWRITE && !s.pslverr;

    // Address decode and read data
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (PADDR)
            ccp_pkg::ADDR_CTRL:     rd_mux[5:0] = s.ctrl;
            ccp_pkg::ADDR_DUTY_UP:  rd_mux[7:0] = s.duty_up;
            ccp_pkg::ADDR_DUTY_BUF: rd_mux[7:0] = s.duty_buf;
            ccp_pkg::ADDR_PERIOD:   rd_mux[7:0] = s.period;
            ccp_pkg::ADDR_TCTRL:    rd_mux[2:0] = s.tctrl;
            ccp_pkg::ADDR_STATUS: begin
                rd_mux[ccp_pkg::ST_MATCH]  = s.match_flag;
                rd_mux[ccp_pkg::ST_PERIOD] = s.period_flag;
            end
            ccp_pkg::ADDR_COUNT: begin
                rd_mux[7:0] = s.count;
                rd_mux[ccp_pkg::CNT_RES_LSB +: 4] = resolution(s.period);
            end
            default:                mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: bus, compare, PWM
    always_comb begin
        next_s          = s;
        next_s.trig     = 1'b0;
        next_s.conv     = 1'b0;
        next_s.tb_clear = 1'b0;
        // APB answer in the first access cycle
        if (PSEL && !PENABLE) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !mapped;
            next_s.prdata  = rd_mux;
        end else if (PENABLE && s.pready) begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
        end
        // Register writes
        if (wr) begin
            unique case (PADDR)
                ccp_pkg::ADDR_CTRL: begin
                    next_s.ctrl = PWDATA[ccp_pkg::CTRL_WIDTH-1:0];
                    if (PWDATA[ccp_pkg::CTRL_WIDTH-1:0] == ccp_pkg::RST_CTRL) begin
                        next_s.cmp_latch = 1'b0;
                        next_s.pin       = 1'b0;
                        next_s.arm       = ARM_IDLE;
                    end
                end
                ccp_pkg::ADDR_DUTY_UP:  next_s.duty_up = PWDATA[7:0];
                ccp_pkg::ADDR_DUTY_BUF: begin
                    if (!is_pwm) begin
                        next_s.duty_buf = PWDATA[7:0];
                    end
                end
                ccp_pkg::ADDR_PERIOD:   next_s.period = PWDATA[7:0];
                ccp_pkg::ADDR_TCTRL:    next_s.tctrl = PWDATA[2:0];
                ccp_pkg::ADDR_STATUS: begin
                    if (PWDATA[ccp_pkg::ST_MATCH]) begin
                        next_s.match_flag = 1'b0;
                    end
                    if (PWDATA[ccp_pkg::ST_PERIOD]) begin
                        next_s.period_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Compare: hardware flag sets win over the status clears above
        if (!SLEEP) begin
            next_s.match_prev = match;
            if (hit) begin
                next_s.match_flag = 1'b1;
                unique case (mode)
                    ccp_pkg::MODE_TOGGLE: next_s.cmp_latch = !s.cmp_latch;
                    ccp_pkg::MODE_SET:    next_s.cmp_latch = 1'b1;
                    ccp_pkg::MODE_CLR:    next_s.cmp_latch = 1'b0;
                    ccp_pkg::MODE_TRIG: begin
                        next_s.trig = 1'b1;
                        next_s.conv = ADC_ENABLE;
                        next_s.arm  = ARM_WAIT;
                    end
                    default: ;
                endcase
            end
            // Clear request only while the match still holds
            if (s.arm == ARM_WAIT && TIMEBASE_TICK) begin
                next_s.arm      = ARM_IDLE;
                next_s.tb_clear = match && (mode == ccp_pkg::MODE_TRIG);
            end
        end
        // Period timer; postscaler plays no part
        if (inc) begin
            if (rollover) begin
                next_s.count       = 8'h00;
                next_s.period_flag = 1'b1;
                if (is_pwm) begin
                    next_s.duty_buf = s.duty_up;
                    next_s.duty_lat = s.ctrl[ccp_pkg::DUTY_LO_LSB +: 2];
                    next_s.pin      = (duty_new != 10'h000);
                end
            end else begin
                next_s.count = s.count + 8'h01;
            end
        end
        // Duty end; a duty past the period never matches
        if (is_pwm && !SLEEP && !rollover && base == {s.duty_buf, s.duty_lat}) begin
            next_s.pin = 1'b0;
        end
        // Selecting MODE_OFF drops the pin level and clears compare and trigger state
        if (next_s.ctrl[3:0] == ccp_pkg::MODE_OFF) begin
            next_s.pin       = 1'b0;
            next_s.cmp_latch = 1'b0;
            next_s.trig      = 1'b0;
            next_s.conv      = 1'b0;
            next_s.tb_clear  = 1'b0;
            next_s.arm       = ARM_IDLE;
        end
        next_s.oe = drives_pin(next_s.ctrl[3:0]);
        // Pin level registered so the output comes from a flop
        next_s.out = next_s.oe && ((next_s.ctrl[3:2] == ccp_pkg::MODE_PWM_TOP) ?
                                   next_s.pin : next_s.cmp_latch);
    end

    // Single state register; any reset restores defaults
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s          <= '0;
            s.ctrl     <= ccp_pkg::RST_CTRL;
            s.duty_up  <= ccp_pkg::RST_BYTE;
            s.duty_buf <= ccp_pkg::RST_BYTE;
            s.period   <= ccp_pkg::RST_BYTE;
            s.tctrl    <= ccp_pkg::RST_TCTRL;
            s.arm      <= ARM_IDLE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs from state flops; no overflow flag is touched by a trigger
    assign PRDATA         = s.prdata;
    assign PREADY         = s.pready;
    assign PSLVERR        = s.pslverr;
    assign CCP_OUT        = s.out;
    assign CCP_OE         = s.oe;
    assign CONV_TRIG      = s.trig;
    assign CONV_START     = s.conv;
    assign TIMEBASE_CLEAR = s.tb_clear;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_roll_pwm;
        rollover && is_pwm && !(wr && PADDR == ccp_pkg::ADDR_CTRL);
    endsequence

    sequence s_trig_hit;
        hit && mode == ccp_pkg::MODE_TRIG && !wr;
    endsequence

    property p_match_flag;
        hit |=> s.match_flag;
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match flag not set");

    property p_zero_ctrl;
        wr && PADDR == ccp_pkg::ADDR_CTRL && PWDATA[5:0] == 6'h00 && !hit
            |=> !s.cmp_latch && !CCP_OE && !CCP_OUT;
    endproperty
    a_zero_ctrl: assert property (p_zero_ctrl) else $error("zero write kept pin");

    property p_swi_pin;
        mode == ccp_pkg::MODE_SWI |-> !CCP_OE;
    endproperty
    a_swi_pin: assert property (p_swi_pin) else $error("software event drove pin");

    property p_trig_conv;
        s_trig_hit |=> CONV_TRIG && (CONV_START == $past(ADC_ENABLE)) && !CCP_OE;
    endproperty
    a_trig_conv: assert property (p_trig_conv) else $error("trigger missing");

    property p_clear_skip;
        s.arm == ARM_WAIT && TIMEBASE_TICK && !match && !SLEEP |=> !TIMEBASE_CLEAR;
    endproperty
    a_clear_skip: assert property (p_clear_skip) else $error("stale clear");

    property p_clear_only_after_trig;
        TIMEBASE_CLEAR |-> $past(s.arm == ARM_WAIT, 1) && !CONV_TRIG;
    endproperty
    a_clear_only_after_trig: assert property (p_clear_only_after_trig)
        else $error("clear without trigger");

    property p_roll_count;
        rollover |=> s.count == 8'h00 && s.period_flag;
    endproperty
    a_roll_count: assert property (p_roll_count) else $error("rollover wrong");

    property p_pwm_set;
        s_roll_pwm ##0 (duty_new != 10'h000) |=> CCP_OUT && s.duty_buf == $past(s.duty_up);
    endproperty
    a_pwm_set: assert property (p_pwm_set) else $error("pwm not set");

    property p_pwm_zero;
        s_roll_pwm ##0 (duty_new == 10'h000) |=> !CCP_OUT;
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty went high");

    property p_buf_ro;
        is_pwm && !rollover && wr && PADDR == ccp_pkg::ADDR_DUTY_BUF |=> $stable(s.duty_buf);
    endproperty
    a_buf_ro: assert property (p_buf_ro) else $error("buffer written in pwm");

    property p_sleep_hold;
        SLEEP |=> $stable(s.count) && $stable(s.pin);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("state moved in sleep");

    property p_off_quiet;
        mode == ccp_pkg::MODE_OFF |-> !CCP_OUT && !CCP_OE && !CONV_TRIG ##1 !CONV_TRIG;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("off unit active");
endmodule

// ---- logic/ccp_pkg.sv ----
// Purpose: Shared constants for the compare and PWM unit
// Assumes: APB byte addressing, 32-bit data, registers in low bits
// Notes:   Reset values and offsets are used by the design and the bench
package ccp_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_DUTY_UP  = 8'h04;
    localparam logic [7:0] ADDR_DUTY_BUF = 8'h08;
    localparam logic [7:0] ADDR_PERIOD   = 8'h0c;
    localparam logic [7:0] ADDR_TCTRL    = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_COUNT    = 8'h18;
    // Control register fields
    localparam int         CTRL_WIDTH    = 6;
    localparam int         DUTY_LO_LSB   = 4;
    localparam int         MODE_LSB      = 0;
    // Mode select codes
    localparam logic [3:0] MODE_OFF      = 4'h0;
    localparam logic [3:0] MODE_TOGGLE   = 4'h2;
    localparam logic [3:0] MODE_SET      = 4'h8;
    localparam logic [3:0] MODE_CLR      = 4'h9;
    localparam logic [3:0] MODE_SWI      = 4'ha;
    localparam logic [3:0] MODE_TRIG     = 4'hb;
    localparam logic [1:0] MODE_PWM_TOP  = 2'h3;
    // Period timer control fields
    localparam int         TC_RUN        = 2;
    localparam logic [1:0] PS_DIV1       = 2'h0;
    localparam logic [1:0] PS_DIV4       = 2'h1;
    // Prescale terminal counts
    localparam logic [3:0] PS_LAST_DIV4  = 4'h3;
    localparam logic [3:0] PS_LAST_DIV16 = 4'hf;
    localparam logic [1:0] PHASE_LAST    = 2'h3;
    // Status bits
    localparam int         ST_MATCH      = 0;
    localparam int         ST_PERIOD     = 1;
    // Reset values
    localparam logic [5:0] RST_CTRL      = 6'h00;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [2:0] RST_TCTRL     = 3'h0;
    // Count register field positions
    localparam int         CNT_RES_LSB   = 8;
endpackage

// ---- logic/ccp_tick_gen.sv ----
// Purpose: Instruction clock phase and prescaler for the period timer
// Assumes: Enable low holds all state (sleep or timer stopped)
// Notes:   Gives the two low timebase bits and the increment pulse
`timescale 1ns/1ps
module ccp_tick_gen (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic [1:0] prescale,
    output logic            inc,
    output logic [1:0]      low_bits
);
    typedef struct packed {
        logic [1:0] phase;
        logic [3:0] pre;
    } tick_t;

    tick_t      st;
    tick_t      next_st;
    logic [3:0] last;

    ////////////////////////////////////////////////////////////////////////
    // Terminal count per prescale and low timebase bits
    always_comb begin
        unique case (prescale)
            ccp_pkg::PS_DIV1: last = 4'h0;
            ccp_pkg::PS_DIV4: last = ccp_pkg::PS_LAST_DIV4;
            default:          last = ccp_pkg::PS_LAST_DIV16;
        endcase
        unique case (prescale)
            ccp_pkg::PS_DIV1: low_bits = st.phase; // System clock phase
            ccp_pkg::PS_DIV4: low_bits = st.pre[1:0];
            default:          low_bits = st.pre[3:2];
        endcase
        inc = enable && (st.phase == ccp_pkg::PHASE_LAST) && (st.pre == last);
    end

    // Phase advances every enabled cycle, prescaler at phase wrap
    always_comb begin
        next_st = st;
        if (enable) begin
            next_st.phase = st.phase + 2'h1;
            if (st.phase == ccp_pkg::PHASE_LAST) begin
                next_st.pre = (st.pre >= last) ? 4'h0 : st.pre + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ---- dv/ccp_load_model.sv ----
// Purpose: Timebase counter and pin load facing the unit
// Assumes: Timebase ticks once every four system clocks
// Notes:   Pin is pulled low while undriven
`timescale 1ns/1ps
module ccp_load_model (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   pin_out,
    input  wire logic   pin_oe,
    input  wire logic   clear,
    output logic [15:0] count,
    output logic        tick,
    output logic        pin,
    output logic [15:0] high_cycles,
    output logic [15:0] period_cycles
);
    logic [1:0]  phase;
    logic [15:0] hi_run;
    logic [15:0] per_run;
    logic        pin_d;
    // Released pin falls to the pull-down level
    assign pin = pin_oe ? pin_out : 1'b0;
    // Synchronous timebase from the instruction clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
            tick  <= 1'b0;
            count <= 16'h0000;
        end else begin
            phase <= phase + 2'h1;
            tick  <= (phase == 2'h3);
            if (clear) count <= 16'h0000;
            else if (tick) count <= count + 16'h0001;
        end
    end
    // Pulse width and period, taken at each rising pin edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_d         <= 1'b0;
            hi_run        <= 16'h0000;
            per_run       <= 16'h0000;
            high_cycles   <= 16'h0000;
            period_cycles <= 16'h0000;
        end else begin
            pin_d <= pin;
            if (pin && !pin_d) begin
                high_cycles   <= hi_run;
                period_cycles <= per_run;
                hi_run        <= 16'h0001;
                per_run       <= 16'h0001;
            end else begin
                hi_run  <= hi_run + {15'h0000, pin};
                per_run <= per_run + 16'h0001;
            end
        end
    end
endmodule

// ---- dv/ccp_compare_and_pwm_test.sv ----
// Purpose: Self-checking bench for the compare and PWM unit
// Assumes: Zero-wait APB slave, 40 MHz system clock
// Notes:   Reads queue expected data for a monitor process
`timescale 1ns/1ps
module ccp_compare_and_pwm_test;
    logic        core_clk, rst, psel, penable, pwrite, adc_en, sleep;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, ccp_out, ccp_oe, conv_trig, conv_start, tb_clear, tb_tick, pin;
    logic [15:0] tb_count, high_c, per_c, r;
    logic [9:0]  d;
    logic [64:0] e;
    logic [64:0] expq[$];
    logic [3:0]  modes[4] = '{ccp_pkg::MODE_SET, ccp_pkg::MODE_TOGGLE, ccp_pkg::MODE_CLR,
                              ccp_pkg::MODE_SWI};
    logic        lvl;
    int          i, k, n_trig, n_start, n_errors, total_checks;
    ccp_compare_pwm i_ccp_compare_pwm (.CORE_CLK(core_clk), .RST(rst), .PADDR(paddr),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TIMEBASE_COUNT(tb_count), .TIMEBASE_TICK(tb_tick),
        .ADC_ENABLE(adc_en), .SLEEP(sleep), .CCP_OUT(ccp_out), .CCP_OE(ccp_oe),
        .CONV_TRIG(conv_trig), .CONV_START(conv_start), .TIMEBASE_CLEAR(tb_clear));
    ccp_load_model i_ccp_load_model (.clk(core_clk), .rst(rst), .pin_out(ccp_out),
        .pin_oe(ccp_oe), .clear(tb_clear), .count(tb_count), .tick(tb_tick), .pin(pin),
        .high_cycles(high_c), .period_cycles(per_c));
    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////
    task summarize;
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk_bus(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: bus %h, expected %h", $time, got, exp);
        end
    endtask
    task chk_sig(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: pin %h, expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; expected read data and error go to the queue
    task apb(input logic [7:0] a, input logic wr, input logic [31:0] v, input logic [31:0] m,
             input logic err);
        expq.push_back({err, m, v});
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= v;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        apb(a, 1'b1, v, 32'h0, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        apb(a, 1'b0, v, m, 1'b0);
    endtask
    // Reference a few ticks ahead, select the mode, wait past the match
    task arm(input logic [3:0] mode);
        r = tb_count + 16'h0008;
        wr(ccp_pkg::ADDR_DUTY_UP, {24'h0, r[7:0]});
        wr(ccp_pkg::ADDR_DUTY_BUF, {24'h0, r[15:8]});
        wr(ccp_pkg::ADDR_CTRL, {28'h0, mode});
        for (k = 0; k < 300 && tb_count !== r; k++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
    endtask
    task hold_chk(input logic v, input int n);
        repeat (n) begin
            @(negedge core_clk);
            chk_sig(pin, v);
        end
    endtask
    ////////////////////////////////////////
    // Bus monitor and pulse counters
    always @(posedge core_clk) begin
        n_trig += conv_trig;
        n_start += conv_start;
        if (psel && penable && pready === 1'b1) begin
            e = expq.pop_front();
            chk_bus(prdata & e[63:32], e[31:0] & e[63:32]);
            chk_bus({31'h0, pslverr}, {31'h0, e[64]});
        end
    end
    // Watchdog
    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        summarize();
    end
    // Main sequence
    initial begin
        {core_clk, psel, penable, pwrite, adc_en, sleep, paddr, pwdata} = '0;
        rst = 1'b1;
        void'($urandom(32'h09f0));
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 6; i++) rd(8'(i * 4), 32'h0, 32'hffff_ffff);
        rd(ccp_pkg::ADDR_COUNT, 32'h0, 32'hff);
        apb(8'h1c, 1'b0, 32'h0, 32'hffff_ffff, 1'b1);
        chk_sig(ccp_oe, 0);
        for (i = 0; i < 4; i++) begin
            if (i == 1) wr(ccp_pkg::ADDR_CTRL, 32'h0);
            arm(modes[i]);
            chk_sig(pin, i < 2);
            chk_sig(ccp_oe, i < 3);
            rd(ccp_pkg::ADDR_STATUS, 32'h1, 32'h1);
            wr(ccp_pkg::ADDR_STATUS, 32'h1);
            rd(ccp_pkg::ADDR_STATUS, 32'h0, 32'h1);
        end
        adc_en <= 1'b1;
        n_trig = 0;
        n_start = 0;
        arm(ccp_pkg::MODE_TRIG);
        repeat (6) @(negedge core_clk);
        chk_sig(tb_count < 16'h3, 1);
        chk_sig(ccp_oe, 0);
        @(posedge core_clk);
        adc_en <= 1'b0;
        for (k = 0; k < 9000 && tb_count !== r; k++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
        chk_sig(n_trig, 2);
        chk_sig(n_start, 1);
        wr(ccp_pkg::ADDR_PERIOD, 32'h3);
        for (i = 0; i < 2; i++) begin
            d = 10'(1 + $urandom % 14);
            wr(ccp_pkg::ADDR_DUTY_UP, {24'h0, d[9:2]});
            wr(ccp_pkg::ADDR_CTRL, {26'h0, d[1:0], ccp_pkg::MODE_PWM_TOP, 2'(i * 3)});
            wr(ccp_pkg::ADDR_TCTRL, {29'h0, 1'b1, 2'(i)});
            repeat (300) @(negedge core_clk);
            chk_sig(per_c, 16 * (i * 3 + 1));
            chk_sig(high_c, d * (i * 3 + 1) + 1);
        end
        rd(ccp_pkg::ADDR_COUNT, 32'h400, 32'hf00);
        wr(ccp_pkg::ADDR_DUTY_BUF, $urandom);
        rd(ccp_pkg::ADDR_DUTY_BUF, {24'h0, d[9:2]}, 32'hff);
        sleep <= 1'b1;
        @(negedge core_clk);
        lvl = pin;
        hold_chk(lvl, 40);
        @(posedge core_clk);
        sleep <= 1'b0;
        wr(ccp_pkg::ADDR_DUTY_UP, 32'h0);
        wr(ccp_pkg::ADDR_CTRL, 32'hc);
        repeat (100) @(negedge core_clk);
        hold_chk(1'b0, 70);
        wr(ccp_pkg::ADDR_DUTY_UP, 32'h20);
        repeat (100) @(negedge core_clk);
        hold_chk(1'b1, 70);
        wr(ccp_pkg::ADDR_CTRL, 32'h0);
        @(negedge core_clk);
        chk_sig(ccp_oe, 0);
        summarize();
    end
endmodule
